// ### rtl/cfg_protect_defs.vh
// Offsets, field positions, reset values and codes for the configuration decoder.
// Assumes a 32-bit Avalon-MM slave with byte addresses; each register is one word.
// What this block does
// - Fail monitor bit set enables clock-fail monitor and switchover; clear disables monitor.
// - Switchover bit enables internal/external clock switchover; clear disables it unless the fail monitor bit is set.
// - Crystal modes ignore clock-out bit; elsewhere 1 gives I/O, 0 drives clock out.
// - Brown-out field: 11 on, 10 on except sleep, 01 software bit, 00 off.
// - Data EEPROM protect bit is active low.
// - Program memory protect bit is active low.
// - Reset pin select ignored under low-voltage programming; else chooses reset or input.
// - Power-up timer enable bit is active low.
// - Watchdog field: 11 on, 10 on except sleep, 01 software bit, 00 off.
// - Three-bit oscillator field picks external clock, internal, RC or crystal.
// - Bulk erase clears program flash, data EEPROM, configuration and EEPROM protection.
// - Low-voltage bit allows low-voltage entry; cannot be cleared in such a session.
// - Debug bit 0 dedicates programming pins to debugger; 1 frees them.
// - Brown-out level bit 1 selects low trip point, 0 high.
// - Stack fault reset bit makes overflow or underflow reset the device.
// - PLL bit enables the four-times frequency multiplier.
// - Unimplemented bits of word two read as 1; reserved bit programmed to 1.
// - Self-write field protects none, 000-1FF, 000-FFF or all 000-1FFF.
// - Program protection blocks external access, external reads give zero, core reads.
// - EEPROM protection blocks external access; core reads and writes still work.
// - Four user ID words at 8000h-8003h, readable and writable.
// - Read-only identity word at 8006h: device field high, revision low.
`ifndef CFG_PROTECT_DEFS_VH
`define CFG_PROTECT_DEFS_VH
`define UID_FIRST_IDX 16'h8000
`define UID_LAST_IDX 16'h8003
`define DEVICE_IDENTITY_WORD_IDX 16'h8006
`define CFG1_IDX 16'h8007
`define CFG2_IDX 16'h8008
`define CTRL_IDX 16'h8010
`define STAT_IDX 16'h8011
`define CTRL_ERASE_BIT 0
`define WORD_ERASED 14'h3FFF
`define CFG2_ONES_MASK 14'h08FC
`define C1_FAILMON_BIT 13
`define C1_SWOVER_BIT 12
`define C1_CLOCK_OUTPUT_PIN_N_BIT 11
`define C1_BOR_HI 10
`define C1_BOR_LO 9
`define C1_EEPROT_N_BIT 8
`define C1_PMPROT_N_BIT 7
`define C1_RSTPIN_BIT 6
`define C1_POWERUP_TIMER_N_BIT 5
`define C1_WDT_HI 4
`define C1_WDT_LO 3
`define C1_OSC_HI 2
`define C1_OSC_LO 0
`define C2_LVP_BIT 13
`define C2_DEBUG_BIT 12
`define C2_BROWNOUT_LEVEL_SELECT_BIT 10
`define C2_STACK_BIT 9
`define C2_PLL_BIT 8
`define C2_WRT_HI 1
`define C2_WRT_LO 0
`define MODE_ALWAYS 2'b11
`define MODE_RUN_ONLY 2'b10
`define MODE_SOFTWARE 2'b01
`define OSC_EXTERNAL_RC_OSCILLATOR 3'h3
`define OSC_INTERNAL 3'h4
`define OSC_XTAL_HIGH 3'h2
`define WRT_LIMIT_SMALL 13'h01FF
`define WRT_LIMIT_HALF 13'h0FFF
`endif

// ### rtl/config_word_protection_decode.v
// Configuration word loader, decoder and code/self-write protection gate.
// Assumes NVM words are stable around reset release and come from logic on mclk.
`include "cfg_protect_defs.vh"
`default_nettype none

module config_word_protection_decode #(
  parameter [8:0] DEVICE_ID = 9'h0A5,  // Arbitrary value
  parameter [4:0] REVISION = 5'h01,    // Arbitrary value
  parameter PM_AW = 13,
  parameter EE_DW = 8
) (
  input wire mclk,
  input wire rstn,
  // Avalon-MM slave
  input wire [17:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Nonvolatile image and programming requests
  input wire [13:0] nvm_cfg1,
  input wire [13:0] nvm_cfg2,
  input wire lv_session,
  output reg nvm_cfg_wr,
  output reg nvm_cfg_wr_sel,
  output reg [13:0] nvm_cfg_wr_data,
  output reg nvm_bulk_erase,
  // Runtime inputs from the core
  input wire in_sleep,
  input wire sw_brownout_en,
  input wire sw_watchdog_en,
  input wire reset_pin_pullup_en,
  input wire stack_fault,
  input wire [PM_AW-1:0] self_wr_addr,
  // External programmer memory paths
  input wire [13:0] pm_ext_rdata_raw,
  output wire [13:0] pm_ext_rdata,
  output wire pm_ext_access_ok,
  input wire [EE_DW-1:0] ee_ext_rdata_raw,
  output wire [EE_DW-1:0] ee_ext_rdata,
  output wire ee_ext_access_ok,
  // Decoded settings
  output wire clock_fail_monitor_on,
  output wire switchover_on,
  output wire [2:0] oscillator_select,
  output wire clock_input_pin_is_io,
  output wire clock_output_pin_osc,
  output wire clock_output_drive,
  output wire brownout_active,
  output wire brownout_low_trip,
  output wire watchdog_active,
  output wire powerup_timer_on,
  output wire master_clear_pin_reset,
  output wire master_clear_pin_pullup,
  output wire low_voltage_entry_ok,
  output wire debugger_owns_pins,
  output wire pll_x4_on,
  output reg stack_reset_req,
  output wire self_write_allowed,
  output wire load_done
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function mode_active;
    input [1:0] mode;
    input sleeping;
    input sw_bit;
    begin
      case (mode)
        `MODE_ALWAYS: mode_active = 1'b1;
        `MODE_RUN_ONLY: mode_active = ~sleeping;
        `MODE_SOFTWARE: mode_active = sw_bit;
        default: mode_active = 1'b0;
      endcase
    end
  endfunction

  function wrt_ok;
    input [1:0] mode;
    input [PM_AW-1:0] addr;
    begin
      case (mode)
        `MODE_ALWAYS: wrt_ok = 1'b1;
        `MODE_RUN_ONLY: wrt_ok = addr > `WRT_LIMIT_SMALL;
        `MODE_SOFTWARE: wrt_ok = addr > `WRT_LIMIT_HALF;
        default: wrt_ok = 1'b0;
      endcase
    end
  endfunction

  function is_mapped;
    input [15:0] idx;
    begin
      is_mapped = (idx >= `UID_FIRST_IDX && idx <= `UID_LAST_IDX) ||
        idx == `DEVICE_IDENTITY_WORD_IDX || idx == `CFG1_IDX || idx == `CFG2_IDX ||
        idx == `CTRL_IDX || idx == `STAT_IDX;
    end
  endfunction

  // ****************************************
  // Load sequence
  // ****************************************
  localparam [1:0] ST_LOAD = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [1:0] state_r;
  reg [13:0] cfg1_r;
  reg [13:0] cfg2_r;

  // Words are caught on the first edge after release, then frozen until next reset
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_LOAD;
      cfg1_r <= `WORD_ERASED;
      cfg2_r <= `WORD_ERASED;
    end else begin
      case (state_r)
        ST_LOAD: begin
          cfg1_r <= nvm_cfg1;
          cfg2_r <= nvm_cfg2 | `CFG2_ONES_MASK;
          state_r <= ST_RUN;
        end
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_LOAD;
      endcase
    end
  end

  assign load_done = state_r[1];

  // ****************************************
  // Field decode
  // ****************************************
  wire [2:0] osc = cfg1_r[`C1_OSC_HI:`C1_OSC_LO];
  wire osc_xtal = osc <= `OSC_XTAL_HIGH;
  wire lvp_on = cfg2_r[`C2_LVP_BIT];
  wire pm_protect = ~cfg1_r[`C1_PMPROT_N_BIT];
  wire ee_protect = ~cfg1_r[`C1_EEPROT_N_BIT];

  assign clock_fail_monitor_on = cfg1_r[`C1_FAILMON_BIT];
  assign switchover_on = cfg1_r[`C1_FAILMON_BIT] | cfg1_r[`C1_SWOVER_BIT];
  assign oscillator_select = osc;
  assign clock_input_pin_is_io = osc == `OSC_INTERNAL;
  assign clock_output_pin_osc = osc_xtal;
  assign clock_output_drive = ~osc_xtal & ~cfg1_r[`C1_CLOCK_OUTPUT_PIN_N_BIT];
  assign brownout_active = mode_active(cfg1_r[`C1_BOR_HI:`C1_BOR_LO],
    in_sleep, sw_brownout_en);
  assign brownout_low_trip = cfg2_r[`C2_BROWNOUT_LEVEL_SELECT_BIT];
  assign watchdog_active = mode_active(cfg1_r[`C1_WDT_HI:`C1_WDT_LO],
    in_sleep, sw_watchdog_en);
  assign powerup_timer_on = ~cfg1_r[`C1_POWERUP_TIMER_N_BIT];
  // Low-voltage programming keeps the pin as reset regardless of select
  assign master_clear_pin_reset = lvp_on | cfg1_r[`C1_RSTPIN_BIT];
  assign master_clear_pin_pullup = master_clear_pin_reset | reset_pin_pullup_en;
  assign low_voltage_entry_ok = lvp_on;
  assign debugger_owns_pins = ~cfg2_r[`C2_DEBUG_BIT];
  assign pll_x4_on = cfg2_r[`C2_PLL_BIT];
  assign self_write_allowed = wrt_ok(cfg2_r[`C2_WRT_HI:`C2_WRT_LO], self_wr_addr);

  // ****************************************
  // External access gating
  // ****************************************
  // Only the programmer path is gated; core fetch and data paths bypass this block
  assign pm_ext_access_ok = ~pm_protect;
  assign pm_ext_rdata = pm_protect ? 14'h0000 : pm_ext_rdata_raw;
  assign ee_ext_access_ok = ~ee_protect;
  assign ee_ext_rdata = ee_protect ? {EE_DW{1'b0}} : ee_ext_rdata_raw;

  // ****************************************
  // Stack fault reset
  // ****************************************
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stack_reset_req <= 1'b0;
    end else begin
      stack_reset_req <= stack_fault & cfg2_r[`C2_STACK_BIT];
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  wire [15:0] idx = address[17:2];
  wire req = read | write;
  wire low_lanes = byteenable[0] & byteenable[1];
  reg ack_r;
  reg [13:0] uid_r [0:3];
  reg lvp_refused_r;

  // One wait cycle per access: decode now, answer on the next edge
  assign waitrequest = req & ~ack_r;

  wire wr_go = write & ack_r & low_lanes;
  wire [13:0] wdata = writedata[13:0];
  wire uid_hit = idx >= `UID_FIRST_IDX && idx <= `UID_LAST_IDX;
  // Clearing the low-voltage bit from inside such a session is refused
  wire cfg2_wr_bad = lv_session & ~wdata[`C2_LVP_BIT];
  wire lvp_refuse = wr_go && idx == `CFG2_IDX && cfg2_wr_bad;

  reg [13:0] rd_word;
  always @* begin
    rd_word = 14'h0000;
    if (uid_hit) begin
      rd_word = uid_r[idx[1:0]];
    end else begin
      case (idx)
        `DEVICE_IDENTITY_WORD_IDX: rd_word = {DEVICE_ID, REVISION};
        `CFG1_IDX: rd_word = cfg1_r;
        `CFG2_IDX: rd_word = cfg2_r | `CFG2_ONES_MASK;
        `STAT_IDX: rd_word = {10'h000, lvp_refused_r, lv_session, ee_protect,
          pm_protect};
        default: rd_word = 14'h0000;
      endcase
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (read & ~ack_r) begin
        readdata <= is_mapped(idx) ? {18'h00000, rd_word} : 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // User ID words
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : uid_gen
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          uid_r[g] <= `WORD_ERASED;
        end else if (nvm_bulk_erase) begin
          uid_r[g] <= `WORD_ERASED;
        end else if (wr_go && uid_hit && idx[1:0] == g) begin
          uid_r[g] <= wdata;
        end
      end
    end
  endgenerate

  // ****************************************
  // Programming requests
  // ****************************************
  // New words reach the running settings only after the next reset
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nvm_cfg_wr <= 1'b0;
      nvm_cfg_wr_sel <= 1'b0;
      nvm_cfg_wr_data <= `WORD_ERASED;
      nvm_bulk_erase <= 1'b0;
      lvp_refused_r <= 1'b0;
    end else begin
      nvm_cfg_wr <= 1'b0;
      nvm_bulk_erase <= 1'b0;
      if (wr_go && idx == `CFG1_IDX) begin
        nvm_cfg_wr <= 1'b1;
        nvm_cfg_wr_sel <= 1'b0;
        nvm_cfg_wr_data <= wdata;
      end
      if (wr_go && idx == `CFG2_IDX && !cfg2_wr_bad) begin
        nvm_cfg_wr <= 1'b1;
        nvm_cfg_wr_sel <= 1'b1;
        nvm_cfg_wr_data <= wdata | `CFG2_ONES_MASK;
      end
      // Erase wipes flash, EEPROM and both words, so EEPROM protection goes too
      if (wr_go && idx == `CTRL_IDX && writedata[`CTRL_ERASE_BIT]) begin
        nvm_bulk_erase <= 1'b1;
      end
      // Refusal flag: set wins over a clear in the same cycle
      if (lvp_refuse) begin
        lvp_refused_r <= 1'b1;
      end else if (wr_go && idx == `STAT_IDX && wdata[3]) begin
        lvp_refused_r <= 1'b0;
      end
    end
  end

endmodule // config_word_protection_decode

`default_nettype wire

// ### dv/nvm_word_store.sv
// Nonvolatile store for both configuration words, far side of the decoder.
// Assumes one-cycle program and erase pulses on mclk; contents survive rstn.
`default_nettype none
module nvm_word_store #(
  parameter logic [13:0] INIT1 = 14'h3FFF,
  parameter logic [13:0] INIT2 = 14'h3FFF
) (
  input wire logic mclk,
  input wire logic nvm_cfg_wr,
  input wire logic nvm_cfg_wr_sel,
  input wire logic [13:0] nvm_cfg_wr_data,
  input wire logic nvm_bulk_erase,
  output logic [13:0] nvm_cfg1,
  output logic [13:0] nvm_cfg2
);
  // ****************
  // Storage
  // ****************
  logic [13:0] w1_r = INIT1;
  logic [13:0] w2_r = INIT2;
  assign nvm_cfg1 = w1_r;
  assign nvm_cfg2 = w2_r;
  // Erased cells read as ones, unimplemented bits included
  always @(posedge mclk) begin
    if (nvm_bulk_erase) begin
      w1_r <= 14'h3FFF;
      w2_r <= 14'h3FFF;
    end else if (nvm_cfg_wr && !nvm_cfg_wr_sel) begin
      w1_r <= nvm_cfg_wr_data;
    end else if (nvm_cfg_wr) begin
      w2_r <= nvm_cfg_wr_data;
    end
  end
endmodule  // nvm_word_store
`default_nettype wire

// ### dv/config_word_protection_decode_checker.sv
// Port-level checker for the configuration decoder.
// Bound from the bench top; sees only the decoder's ports.
`default_nettype none
module config_word_protection_decode_checker #(
  parameter int EE_DW = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic pm_ext_access_ok,
  input wire logic [13:0] pm_ext_rdata,
  input wire logic [13:0] pm_ext_rdata_raw,
  input wire logic ee_ext_access_ok,
  input wire logic [EE_DW-1:0] ee_ext_rdata,
  input wire logic stack_fault,
  input wire logic stack_reset_req,
  input wire logic load_done,
  input wire logic clock_fail_monitor_on,
  input wire logic switchover_on,
  input wire logic clock_output_pin_osc,
  input wire logic clock_output_drive,
  input wire logic [2:0] oscillator_select,
  input wire logic pll_x4_on,
  input wire logic nvm_bulk_erase
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence req_s;
    (read || write) && waitrequest;
  endsequence
  sequence ack_s;
    !waitrequest;
  endsequence
  wait_one_a: assert property (req_s |=> ack_s) else $error("bus answer late");
  pm_block_a: assert property (!pm_ext_access_ok |-> pm_ext_rdata == 14'h0000)
    else $error("protected program read not zero");
  pm_pass_a: assert property (pm_ext_access_ok |-> pm_ext_rdata == pm_ext_rdata_raw)
    else $error("program read altered");
  ee_block_a: assert property (!ee_ext_access_ok |-> ee_ext_rdata == '0)
    else $error("protected eeprom read leaked");
  stack_req_a: assert property (stack_reset_req |-> $past(stack_fault))
    else $error("stack reset without fault");
  hold_cfg_a: assert property (load_done && $past(load_done)
    |-> $stable(oscillator_select) && $stable(pll_x4_on))
    else $error("settings moved while running");
  mon_switch_a: assert property (clock_fail_monitor_on |-> switchover_on)
    else $error("monitor without switchover");
  clock_output_pin_osc_a: assert property (clock_output_pin_osc
    |-> !clock_output_drive && oscillator_select <= 3'h2)
    else $error("clock out pin misused");
  erase_one_a: assert property (nvm_bulk_erase |=> !nvm_bulk_erase)
    else $error("erase pulse too long");
endmodule  // config_word_protection_decode_checker
`default_nettype wire

// ### dv/config_word_protection_decode_tb_top.sv
// Bench top: bus tasks, decode and protection scenarios, verdict.
// Assumes the NVM store model and the bound port checker.
`default_nettype none
module config_word_protection_decode_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [8:0] DEV = 9'h0B3;  // Arbitrary value
  localparam logic [4:0] REV = 5'h06;  // Arbitrary value
  logic mclk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, lv_session = 1'b0;
  logic in_sleep = 1'b0, sw_brownout_en = 1'b0, sw_watchdog_en = 1'b0;
  logic reset_pin_pullup_en = 1'b0, stack_fault = 1'b0;
  logic [17:0] address = 18'h00000;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [3:0] byteenable = 4'hF;
  logic [12:0] self_wr_addr = 13'h0000;
  logic [13:0] pm_ext_rdata_raw = 14'h2AD5, nvm_cfg1, nvm_cfg2, nvm_cfg_wr_data, pm_ext_rdata, w1, w2;
  logic [7:0] ee_ext_rdata_raw = 8'hA5, ee_ext_rdata;
  logic [2:0] oscillator_select;
  logic [1:0] m;
  logic waitrequest, nvm_cfg_wr, nvm_cfg_wr_sel, nvm_bulk_erase, pm_ext_access_ok, e;
  logic ee_ext_access_ok, clock_fail_monitor_on, switchover_on, clock_input_pin_is_io;
  logic clock_output_pin_osc, clock_output_drive, brownout_active, brownout_low_trip;
  logic watchdog_active, powerup_timer_on, master_clear_pin_reset, master_clear_pin_pullup;
  logic low_voltage_entry_ok, debugger_owns_pins, pll_x4_on, stack_reset_req;
  logic self_write_allowed, load_done;
  logic [12:0] lims [4] = '{13'h01FF, 13'h0200, 13'h0FFF, 13'h1000};
  int mismatches = 0, comparisons = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  config_word_protection_decode #(.DEVICE_ID(DEV), .REVISION(REV)) i_config_word_protection_decode (
    .mclk, .rstn, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .nvm_cfg1, .nvm_cfg2, .lv_session, .nvm_cfg_wr, .nvm_cfg_wr_sel, .nvm_cfg_wr_data,
    .nvm_bulk_erase, .in_sleep, .sw_brownout_en, .sw_watchdog_en, .reset_pin_pullup_en,
    .stack_fault, .self_wr_addr, .pm_ext_rdata_raw, .pm_ext_rdata, .pm_ext_access_ok,
    .ee_ext_rdata_raw, .ee_ext_rdata, .ee_ext_access_ok, .clock_fail_monitor_on, .switchover_on,
    .oscillator_select, .clock_input_pin_is_io, .clock_output_pin_osc, .clock_output_drive,
    .brownout_active, .brownout_low_trip, .watchdog_active, .powerup_timer_on,
    .master_clear_pin_reset, .master_clear_pin_pullup, .low_voltage_entry_ok,
    .debugger_owns_pins, .pll_x4_on, .stack_reset_req, .self_write_allowed, .load_done);
  nvm_word_store i_nvm_word_store (.mclk, .nvm_cfg_wr, .nvm_cfg_wr_sel, .nvm_cfg_wr_data,
    .nvm_bulk_erase, .nvm_cfg1, .nvm_cfg2);
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    comparisons++;
    if (g !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, g);
    end
  endtask
  // Request held until the rising edge that samples waitrequest low; data taken there
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (waitrequest !== 1'b0) chk("answer", 32'h0, 32'h1);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic pulse_reset();
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    pulse_reset();
    for (int i = 0; i < 8; i++) begin
      w1 = {i[0], i[1], i[0], i[1:0], i[2], ~i[0], i[1], i[0], i[1:0], i[2:0]};
      w2 = {i[2], i[0], 1'b0, i[1], i[1], i[0], 6'h00, i[1:0]};
      m = i[1:0];
      acc(1'b1, 16'h8007, {18'h0, w1});
      acc(1'b1, 16'h8008, {18'h0, w2});
      pulse_reset();
      acc(1'b0, 16'h8007, 32'h0);
      chk("word_one", {18'h0, w1}, rd);
      acc(1'b0, 16'h8008, 32'h0);
      chk("word_two", {18'h0, w2 | 14'h08FC}, rd);
      chk("osc", {i[2:0], i < 3, i == 4, i > 2 && !w1[11]}, {oscillator_select,
        clock_output_pin_osc, clock_input_pin_is_io, clock_output_drive});
      chk("clocks", {w1[13], w1[13] | w1[12], w2[8], ~w2[12], w2[13] | w1[6]},
        {clock_fail_monitor_on, switchover_on, pll_x4_on, debugger_owns_pins,
        master_clear_pin_reset});
      chk("protect", {w1[7], w1[8], w1[7] ? 14'h2AD5 : 14'h0000, w1[8] ? 8'hA5 : 8'h00,
        ~w1[5], w2[10], w2[13]}, {pm_ext_access_ok, ee_ext_access_ok, pm_ext_rdata, ee_ext_rdata,
        powerup_timer_on, brownout_low_trip, low_voltage_entry_ok});
      for (int s = 0; s < 2; s++) begin
        @(posedge mclk);
        {in_sleep, sw_watchdog_en, sw_brownout_en, reset_pin_pullup_en} <= {4{s[0]}};
        @(negedge mclk);
        e = (m == 2'b11) || (m == 2'b10 && !s[0]) || (m == 2'b01 && s[0]);
        chk("modes", {e, e, w2[13] | w1[6] | s[0]},
          {watchdog_active, brownout_active, master_clear_pin_pullup});
      end
      foreach (lims[k]) begin
        @(posedge mclk);
        self_wr_addr <= lims[k];
        @(negedge mclk);
        chk("self_write", (m == 2'b11) || (m == 2'b10 && lims[k] > 13'h01FF)
          || (m == 2'b01 && lims[k] > 13'h0FFF), self_write_allowed);
      end
      @(posedge mclk);
      stack_fault <= 1'b1;
      @(posedge mclk);
      stack_fault <= 1'b0;
      @(negedge mclk);
      chk("stack", w2[9], stack_reset_req);
      $display("test decode %0d done", i);
    end
    acc(1'b1, 16'h8006, 32'h0);
    acc(1'b0, 16'h8006, 32'h0);
    chk("identity", {18'h0, DEV, REV}, rd);
    acc(1'b1, 16'h8003, 32'h2ABC);
    acc(1'b0, 16'h8003, 32'h0);
    chk("user_id", 32'h2ABC, rd);
    acc(1'b0, 16'h8005, 32'h0);
    chk("unmapped", 32'h0, rd);
    lv_session <= 1'b1;
    acc(1'b1, 16'h8008, 32'h1FFF);
    acc(1'b0, 16'h8011, 32'h0);
    chk("refused", 32'h3, {30'h0, rd[3:2]});
    lv_session <= 1'b0;
    pulse_reset();
    acc(1'b0, 16'h8008, 32'h0);
    chk("kept", {18'h0, w2 | 14'h08FC}, rd);
    $display("test identity and refusal done");
    acc(1'b1, 16'h8007, 32'h3E7F);
    pulse_reset();
    chk("protected", 32'h0, {30'h0, ee_ext_access_ok, pm_ext_access_ok});
    acc(1'b1, 16'h8000, 32'h1234);
    acc(1'b1, 16'h8010, 32'h1);
    acc(1'b0, 16'h8000, 32'h0);
    chk("erased_id", 32'h3FFF, rd);
    pulse_reset();
    acc(1'b0, 16'h8007, 32'h0);
    chk("erased_word", 32'h3FFF, rd);
    chk("erased_prot", 32'h3, {30'h0, ee_ext_access_ok, pm_ext_access_ok});
    $display("test bulk erase done");
    give_verdict();
  end
endmodule  // config_word_protection_decode_tb_top
bind config_word_protection_decode config_word_protection_decode_checker #(.EE_DW(EE_DW))
  i_config_word_protection_decode_checker (.mclk, .rstn, .read, .write, .waitrequest,
  .pm_ext_access_ok, .pm_ext_rdata, .pm_ext_rdata_raw, .ee_ext_access_ok, .ee_ext_rdata,
  .stack_fault, .stack_reset_req, .load_done, .clock_fail_monitor_on, .switchover_on,
  .clock_output_pin_osc, .clock_output_drive, .oscillator_select, .pll_x4_on, .nvm_bulk_erase);
`default_nettype wire
